// ==== rtl/nand_status_id_reset_control.sv ====
// Purpose: Host controller that issues status read, ID read and reset to a NAND flash.
// Assumes: Flash pins synchronous to clk; completion_line pulled up outside.
// Notes: One request at a time; req is taken only while ready is high.
`timescale 1ns/10ps

module nand_status_id_reset_control
  import nand_host_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // User request side
  input wire logic req,
  input wire op_t req_op,
  input wire logic lock_release,
  output logic ready,
  output logic done,
  output logic timeout,
  output logic [7:0] status,
  output logic [31:0] ident,
  // Flash pins
  output flash_ctl_t flash_ctl,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic completion_line
);

  host_state_t s_q, s_d;

  // No program command exists in this set, so the partial-program limits always hold.
  function automatic logic [7:0] cmd_code(input op_t op);
    unique case (op)
      OP_STATUS: cmd_code = CMD_STATUS;
      OP_IDENT: cmd_code = CMD_IDENT;
      OP_RESET: cmd_code = CMD_RESET;
      OP_READ_MAIN: cmd_code = CMD_READ_MAIN;
    endcase
  endfunction

  localparam logic [CNT_W-1:0] STROBE_C = CNT_W'(STROBE_CYC);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.cnt = (s_q.cnt != '0) ? s_q.cnt - 1'b1 : s_q.cnt;
    unique case (s_q.st)
      ST_POWER: begin
        if (s_q.cnt == '0) begin
          s_d.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        s_d.ctl.ce_n = 1'b1;
        if (lock_release) begin
          s_d.ctl.write_lock_n = 1'b1;
        end
        if (req) begin
          s_d.op = req_op;
          s_d.timeout = 1'b0;
          s_d.idx = '0;
          s_d.ctl.ce_n = 1'b0;
          s_d.ctl.cle = 1'b1;
          s_d.ctl.we_n = 1'b0;
          s_d.dout = cmd_code(req_op);
          s_d.dout_en = 1'b1;
          s_d.cnt = STROBE_C;
          s_d.st = ST_CMD_LO;
        end
      end
      ST_CMD_LO: begin
        if (s_q.cnt == '0) begin
          s_d.ctl.we_n = 1'b1;
          s_d.cnt = STROBE_C;
          s_d.st = ST_CMD_HI;
        end
      end
      ST_CMD_HI: begin
        if (s_q.cnt == '0) begin
          s_d.ctl.cle = 1'b0;
          s_d.dout_en = 1'b0;
          unique case (s_q.op)
            OP_IDENT: begin
              s_d.ctl.ale = 1'b1;
              s_d.ctl.we_n = 1'b0;
              s_d.dout = ADDR_IDENT;
              s_d.dout_en = 1'b1;
              s_d.cnt = STROBE_C;
              s_d.st = ST_ADR_LO;
            end
            OP_RESET: begin
              s_d.cnt = CNT_W'(WB_CYC);
              s_d.busy_seen = 1'b0;
              s_d.st = ST_BUSY;
            end
            OP_STATUS: begin
              s_d.cnt = CNT_W'(WHR_CYC);
              s_d.st = ST_GAP;
            end
            OP_READ_MAIN: begin
              s_d.st = ST_DONE;
            end
          endcase
        end
      end
      ST_ADR_LO: begin
        if (s_q.cnt == '0) begin
          s_d.ctl.we_n = 1'b1;
          s_d.cnt = STROBE_C;
          s_d.st = ST_ADR_HI;
        end
      end
      ST_ADR_HI: begin
        if (s_q.cnt == '0) begin
          s_d.ctl.ale = 1'b0;
          s_d.dout_en = 1'b0;
          s_d.cnt = CNT_W'(WHR_CYC);
          s_d.st = ST_GAP;
        end
      end
      ST_GAP: begin
        if (s_q.cnt == '0) begin
          // Chip select is already low, so this falling strobe is the later edge.
          s_d.ctl.output_strobe_n = 1'b0;
          s_d.cnt = STROBE_C;
          s_d.st = ST_RD_LO;
        end
      end
      ST_RD_LO: begin
        if (s_q.cnt == '0) begin
          s_d.ctl.output_strobe_n = 1'b1;
          if (s_q.op == OP_STATUS) begin
            s_d.status = io_in;
            s_d.st = ST_DONE;
          end else begin
            // Maker code lands in the top byte, fourth byte in the bottom.
            s_d.ident = {s_q.ident[23:0], io_in};
            s_d.idx = s_q.idx + 1'b1;
            s_d.cnt = STROBE_C;
            s_d.st = (s_q.idx == 2'(ID_BYTES - 1)) ? ST_DONE : ST_RD_HI;
          end
        end
      end
      ST_RD_HI: begin
        if (s_q.cnt == '0) begin
          s_d.ctl.output_strobe_n = 1'b0;
          s_d.cnt = STROBE_C;
          s_d.st = ST_RD_LO;
        end
      end
      ST_BUSY: begin
        // The long wait is armed as soon as the line is seen low, or when the onset
        // window ends, so a fast busy onset never runs into the short window count.
        if (!s_q.busy_seen) begin
          if (!completion_line || s_q.cnt == '0) begin
            s_d.busy_seen = 1'b1;
            s_d.cnt = CNT_W'(RESET_MAX_CYC);
          end
        end else if (completion_line) begin
          s_d.status = STATUS_AFTER_RESET;
          s_d.status[7] = s_q.ctl.write_lock_n;
          s_d.st = ST_DONE;
        end else if (s_q.cnt == '0) begin
          s_d.timeout = 1'b1;
          s_d.st = ST_DONE;
        end
      end
      ST_DONE: begin
        s_d.ctl.ce_n = 1'b1;
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{st: ST_POWER, op: OP_STATUS,
               ctl: '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                      output_strobe_n: 1'b1, write_lock_n: 1'b0},
               dout: 8'h00, dout_en: 1'b0, idx: 2'h0,
               cnt: CNT_W'(POWER_UP_CYC), status: 8'h00, ident: 32'h0,
               busy_seen: 1'b0, timeout: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ready = (s_q.st == ST_IDLE);
  assign done = (s_q.st == ST_DONE);
  assign timeout = s_q.timeout;
  assign status = s_q.status;
  assign ident = s_q.ident;
  assign flash_ctl = s_q.ctl;
  assign io_out = s_q.dout;
  assign io_oe = s_q.dout_en;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  power_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> (s_q.st == ST_POWER)[*8])
    else $error("command left power wait too early");
  lock_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ST_POWER) |-> !flash_ctl.write_lock_n)
    else $error("write lock released during power-up");
  status_cmd_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ready && req && req_op == OP_STATUS) |=> (io_out == CMD_STATUS && flash_ctl.cle))
    else $error("status command code wrong");
  strobe_late_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(flash_ctl.output_strobe_n) |-> !flash_ctl.ce_n && !io_oe)
    else $error("output strobe fell with chip deselected or bus driven");
  ident_addr_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(flash_ctl.ale) |-> (io_out == ADDR_IDENT && s_q.op == OP_IDENT))
    else $error("ident address cycle wrong");
  ident_count_a: assert property (@(posedge clk) disable iff (!rst_b)
    (done && s_q.op == OP_IDENT) |-> s_q.idx == 2'h0)
    else $error("ident did not read four bytes");
  reset_status_a: assert property (@(posedge clk) disable iff (!rst_b)
    (done && s_q.op == OP_RESET && !timeout && flash_ctl.write_lock_n)
      |-> status == STATUS_AFTER_RESET)
    else $error("status after reset not C0");
  reset_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ST_BUSY && !completion_line) |=> (!done || timeout))
    else $error("reset completed while line low");
  single_strobe_a: assert property (@(posedge clk) disable iff (!rst_b)
    (s_q.st == ST_BUSY) |-> flash_ctl.we_n)
    else $error("command written during reset busy");
  status_c: cover property (@(posedge clk) disable iff (!rst_b)
    done && s_q.op == OP_STATUS);
  ident_c: cover property (@(posedge clk) disable iff (!rst_b)
    done && s_q.op == OP_IDENT);
  reset_c: cover property (@(posedge clk) disable iff (!rst_b)
    done && s_q.op == OP_RESET && !timeout);

endmodule // nand_status_id_reset_control

// ==== rtl/nand_host_pkg.sv ====
// Purpose: Shared constants and carrier types for the NAND status, ID and reset host.
// Assumes: 25 MHz clock, 8-bit multiplexed flash bus.
// Notes: Timing counts derive from times in their own units.
package nand_host_pkg;

  localparam int unsigned CLK_MHZ = 25;
  // Flash command codes, ID address, status values and ID byte count.
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_READ_MAIN = 8'h00;
  localparam logic [7:0] ADDR_IDENT = 8'h00;
  localparam logic [7:0] STATUS_AFTER_RESET = 8'hc0;
  localparam int unsigned STATUS_READY_BIT = 6;
  localparam int unsigned ID_BYTES = 4;
  // Power-up wait, least time, rounded up.
  localparam int unsigned POWER_UP_US = 10;
  localparam int unsigned POWER_UP_CYC = POWER_UP_US * CLK_MHZ;
  // Longest reset busy, read/program/erase worst case 500 us.
  localparam int unsigned RESET_MAX_US = 500;
  localparam int unsigned RESET_MAX_CYC = RESET_MAX_US * CLK_MHZ;
  // Strobe phase length; 80 ns per half covers setup, access and cycle times.
  localparam int unsigned STROBE_NS = 80;
  localparam int unsigned STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  // Write high to read low, 60 ns least.
  localparam int unsigned WHR_NS = 60;
  localparam int unsigned WHR_CYC = (WHR_NS * CLK_MHZ + 999) / 1000;
  // Write high to busy, 100 ns longest: wait this long before sampling ready.
  localparam int unsigned WB_NS = 100;
  localparam int unsigned WB_CYC = (WB_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 20;

  typedef enum logic [1:0] {
    OP_STATUS = 2'b00,
    OP_IDENT = 2'b01,
    OP_RESET = 2'b10,
    OP_READ_MAIN = 2'b11
  } op_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic output_strobe_n;
    logic write_lock_n;
  } flash_ctl_t;

  typedef enum logic [3:0] {
    ST_POWER = 4'h0,
    ST_IDLE = 4'h1,
    ST_CMD_LO = 4'h2,
    ST_CMD_HI = 4'h3,
    ST_ADR_LO = 4'h4,
    ST_ADR_HI = 4'h5,
    ST_GAP = 4'h6,
    ST_RD_LO = 4'h7,
    ST_RD_HI = 4'h8,
    ST_BUSY = 4'h9,
    ST_DONE = 4'ha
  } state_t;

  typedef struct packed {
    state_t st;
    op_t op;
    flash_ctl_t ctl;
    logic [7:0] dout;
    logic dout_en;
    logic [1:0] idx;
    logic [CNT_W-1:0] cnt;
    logic [7:0] status;
    logic [31:0] ident;
    logic busy_seen;
    logic timeout;
  } host_state_t;

endpackage

// ==== bench/nand_flash_model.sv ====
// Purpose: Behavioural flash device answering status, ID and reset commands.
// Assumes: Host pins follow the strobe protocol; ready/busy is pulled up outside.
// Notes: No cell array; reset busy length is set by the bench through busy_ns.
`timescale 1ns/10ps
module nand_flash_model
  import nand_host_pkg::*;
#(
  parameter logic [31:0] ID_CODE = 32'h5a3c1122 // Arbitrary identification bytes.
)(
  // Host pins and bench-set busy length
  input wire flash_ctl_t ctl,
  input wire logic [7:0] host_io,
  input wire logic host_oe,
  input wire logic [23:0] busy_ns,
  // Device pins
  output logic [7:0] bus_io,
  output logic rb_pull
);
  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [1:0] mode_q;
  logic [1:0] idx_q;
  logic [7:0] last_q;
  logic [7:0] dev_val;
  logic dev_drive;
  initial begin
    mode_q = 2'h0;
    idx_q = 2'h0;
    last_q = 8'h00;
    rb_pull = 1'b0;
  end
  assign dev_drive = !ctl.ce_n && !ctl.output_strobe_n;
  always_comb begin
    if (mode_q == 2'h3) dev_val = ID_CODE[8*(3-idx_q) +: 8];
    else dev_val = {ctl.write_lock_n, !rb_pull, 6'h00};
  end
  // A released bus shows the inverse of its last value, never a stale copy.
  assign bus_io = host_oe ? host_io : (dev_drive ? dev_val : ~last_q);
  always @(bus_io) if (host_oe || dev_drive) last_q = bus_io;
  // ----------------------------------------
  // Command register
  // ----------------------------------------
  always @(posedge ctl.we_n) begin
    if (!ctl.ce_n && ctl.cle) begin
      if (host_io == CMD_RESET) begin
        if (!rb_pull) begin
          // No cell array is modelled, so aborted cells simply hold nothing valid.
          mode_q = 2'h0;
          rb_pull = 1'b1;
          // Release a little off the clock edge so the host never samples it mid-change.
          fork
            #(busy_ns + 24'd5) rb_pull = 1'b0;
          join_none
        end
      end else if (host_io == CMD_STATUS) mode_q = 2'h1;
      else if (host_io == CMD_IDENT) mode_q = 2'h2;
      else mode_q = 2'h0;
    end else if (!ctl.ce_n && ctl.ale && mode_q == 2'h2 && host_io == ADDR_IDENT) begin
      mode_q = 2'h3;
      idx_q = 2'h0;
    end
  end
  always @(posedge ctl.output_strobe_n) if (mode_q == 2'h3 && !ctl.ce_n) idx_q = idx_q + 2'h1;
endmodule // nand_flash_model

// ==== bench/nand_status_id_reset_control_tb.sv ====
// Purpose: Self-checking bench for the status, ID and reset host.
// Assumes: Flash model on the pins; completion_line pulled up here.
// Notes: Table rows first, then reset timing, timeout and a final reset asserted in the done state, then a status read with the lock pin low.
`timescale 1ns/10ps
module nand_status_id_reset_control_tb;
  import nand_host_pkg::*;
  localparam logic [31:0] ID_CODE = 32'h5a3c1122; // Arbitrary identification bytes.
  typedef struct packed {op_t op; logic lock; logic [7:0] st; logic [31:0] id;} row_t;
  logic clk, rst_b, req, lock_release, ready, done, timeout, io_oe, rb_pull, completion_line;
  op_t req_op;
  logic [7:0] status, io_out, io_in;
  logic [31:0] ident;
  flash_ctl_t flash_ctl;
  logic [23:0] busy_ns;
  int num_errors, check_count, n;
  row_t rows [6];
  assign completion_line = rb_pull ? 1'b0 : 1'b1;
  always #20 clk = ~clk;
  nand_status_id_reset_control DUT (.clk(clk), .rst_b(rst_b), .req(req), .req_op(req_op),
    .lock_release(lock_release), .ready(ready), .done(done), .timeout(timeout),
    .status(status), .ident(ident), .flash_ctl(flash_ctl), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .completion_line(completion_line));
  nand_flash_model #(.ID_CODE(ID_CODE)) flash (.ctl(flash_ctl), .host_io(io_out),
    .host_oe(io_oe), .busy_ns(busy_ns), .bus_io(io_in), .rb_pull(rb_pull));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic run_op(input op_t op, output int cyc);
    cyc = 0;
    while (ready !== 1'b1 && cyc < 20000) begin @(negedge clk); cyc++; end
    req_op = op;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    cyc = 0;
    while (done !== 1'b1 && cyc < 20000) begin @(negedge clk); cyc++; end
  endtask
  task automatic reset_cycle();
    rst_b = 1'b0;
    repeat (5) @(negedge clk);
    check("ctl_in_reset", flash_ctl, 6'b100110);
    check("idle_in_reset", {22'h0, ready, io_oe, status}, 32'h0);
    check("ident_in_reset", ident, 32'h0);
    rst_b = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 1000) begin @(negedge clk); n++; end
    check("power_up_wait", n >= POWER_UP_CYC && n < 1000, 1'b1);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    #1_200_000;
    num_errors++;
    summarize();
  end
  initial begin
    clk = 1'b0; rst_b = 1'b0; req = 1'b0; req_op = OP_STATUS; lock_release = 1'b0;
    busy_ns = 24'd2000; num_errors = 0; check_count = 0;
    rows = '{'{OP_STATUS, 1'b0, 8'h40, 32'h0}, '{OP_IDENT, 1'b0, 8'h40, ID_CODE},
      '{OP_RESET, 1'b0, 8'h40, ID_CODE}, '{OP_STATUS, 1'b1, 8'hc0, ID_CODE},
      '{OP_READ_MAIN, 1'b1, 8'hc0, ID_CODE}, '{OP_IDENT, 1'b1, 8'hc0, ID_CODE}};
    reset_cycle();
    foreach (rows[i]) begin
      lock_release = rows[i].lock;
      run_op(rows[i].op, n);
      check("status", status, rows[i].st);
      check("ident", ident, rows[i].id);
      check("lock_pin", flash_ctl.write_lock_n, rows[i].lock);
    end
    // The reset must wait out the full 2 us device busy, 50 cycles.
    run_op(OP_RESET, n);
    check("reset_wait", n >= 50 && n < 200, 1'b1);
    check("reset_status", {timeout, status}, 9'h0c0);
    run_op(OP_STATUS, n);
    check("status_after_reset", status, 8'hc0);
    // A device stuck busy past 500 us must be flagged.
    busy_ns = 24'd600000;
    run_op(OP_RESET, n);
    check("timeout_flag", timeout, 1'b1);
    check("timeout_len", n >= RESET_MAX_CYC && n < 13000, 1'b1);
    n = 0;
    while (completion_line !== 1'b1 && n < 5000) begin @(negedge clk); n++; end
    busy_ns = 24'd2000;
    run_op(OP_STATUS, n);
    check("status_after_timeout", status, 8'hc0);
    lock_release = 1'b0;
    reset_cycle();
    run_op(OP_STATUS, n);
    check("status_lock_low", status, 8'h40);
    summarize();
  end
endmodule // nand_status_id_reset_control_tb
